// ===== core/wmd_pkg.sv
// ****************************************
// multiply datapath constants
// ****************************************
package wmd_pkg;

	localparam int unsigned WORD_W = 32;
	localparam int unsigned IDX_W = 4;
	localparam int unsigned OP_W = 3;

	// operation select codes
	localparam logic [OP_W-1:0] OP_PRODUCT_LOW = 3'h0;
	localparam logic [OP_W-1:0] OP_PLUS_ADDEND = 3'h1;
	localparam logic [OP_W-1:0] OP_MINUS_ADDEND = 3'h2;
	localparam logic [OP_W-1:0] OP_WIDE_PRODUCT = 3'h3;
	localparam logic [OP_W-1:0] OP_WIDE_DOUBLE_ACC = 3'h4;
	localparam logic [OP_W-1:0] OP_WIDE_ACC = 3'h5;

	// register file indices the issuer must keep away from, and the highest index a flag-setting product may use
	localparam logic [IDX_W-1:0] IDX_STACK_POINTER = 4'hd;
	localparam logic [IDX_W-1:0] IDX_PROGRAM_COUNTER = 4'hf;
	localparam logic [IDX_W-1:0] IDX_LOW_LIMIT = 4'h7;

	// cycles from issue to write-back
	localparam int unsigned RESULT_LATENCY = 1;

	localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
	localparam logic [IDX_W-1:0] IDX_RESET = 4'h0;

endpackage

// ===== core/wmd_mul_unsigned.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// full unsigned word product
// ****************************************
module wmd_mul_unsigned (
	input wire logic [31:0] opA,
	input wire logic [31:0] opB,
	output logic [63:0] product
);

	// one full-width product feeds both the word and the wide results
	always_comb begin
		product = {32'h0000_0000, opA} * {32'h0000_0000, opB}; // RULE17
	end

endmodule // wmd_mul_unsigned

`default_nettype wire

// ===== core/wmd_add_wide.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// wide add or reverse subtract
// ****************************************
module wmd_add_wide #(
	parameter int unsigned W = 64
) (
	input wire logic [W-1:0] termA,
	input wire logic [W-1:0] termB,
	input wire logic reverseSub,
	output logic [W-1:0] sum
);

	// reverse subtract gives termB - termA, as the addend comes first
	always_comb begin
		if (reverseSub) begin
			sum = termB - termA;
		end else begin
			sum = termA + termB;
		end
	end

endmodule // wmd_add_wide

`default_nettype wire

// ===== core/wmd_wide_multiply_datapath.sv
`timescale 1ns/100ps
`default_nettype none

// Contract
// RULE1: plain product writes only the low 32 bits of the product.
// RULE2: product plus addend writes the low 32 bits of that sum.
// RULE3: addend minus product writes the low 32 bits of the difference.
// RULE4: word results are the same for signed and unsigned operands.
// RULE5: with no destination named, the first operand register is written.
// RULE6: plain product touches the flags only when flag update is asked.
// RULE7: flag-updating product sets negative and zero, not carry/overflow.
// RULE8: issuer of flag-setting product uses R0-R7, dest equal second, no cond.
// RULE9: issuer never names stack pointer or program counter.
// RULE10: wide operations treat both operands as unsigned 32-bit values.
// RULE11: wide product writes low word to low dest and high word to high dest.
// RULE12: double accumulate adds prior high then prior low, zero-extended.
// RULE13: double accumulate writes upper sum word high and lower word low.
// RULE14: wide accumulate adds the product to the high:low pair and writes it.
// RULE15: issuer names two distinct high and low destination registers.
// RULE16: no wide operation alters any flag.
// RULE17: one full 64-bit unsigned product feeds every result.
module wmd_wide_multiply_datapath (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic issueValid,
	input wire logic [wmd_pkg::OP_W-1:0] opSel,
	input wire logic flagUpdate,
	input wire logic condUsed,
	input wire logic destNamed,
	input wire logic [wmd_pkg::IDX_W-1:0] destIdx,
	input wire logic [wmd_pkg::IDX_W-1:0] firstIdx,
	input wire logic [wmd_pkg::IDX_W-1:0] secondIdx,
	input wire logic [wmd_pkg::IDX_W-1:0] addendIdx,
	input wire logic [wmd_pkg::IDX_W-1:0] destHighIdx,
	input wire logic [wmd_pkg::IDX_W-1:0] destLowIdx,
	input wire logic [31:0] firstVal,
	input wire logic [31:0] secondVal,
	input wire logic [31:0] addendVal,
	input wire logic [31:0] destHighVal,
	input wire logic [31:0] destLowVal,
	output logic wrLowValid,
	output logic [wmd_pkg::IDX_W-1:0] wrLowIdx,
	output logic [31:0] wrLowData,
	output logic wrHighValid,
	output logic [wmd_pkg::IDX_W-1:0] wrHighIdx,
	output logic [31:0] wrHighData,
	output logic flagWrite,
	output logic flagNeg,
	output logic flagZero,
	output logic misuse
);

	// ****************************************
	// arithmetic
	// ****************************************
	logic [63:0] product;
	logic [63:0] accFirst;
	logic [63:0] accSecond;
	logic subFirst;
	logic [63:0] sumFirst;
	logic [63:0] sumFinal;

	wmd_mul_unsigned uMul (
		.opA(firstVal),
		.opB(secondVal),
		.product(product)
	);

	always_comb begin
		accFirst = '0;
		accSecond = '0;
		subFirst = 1'b0;
		case (opSel)
			wmd_pkg::OP_PLUS_ADDEND: begin
				accFirst = {32'h0000_0000, addendVal}; // RULE2
			end
			wmd_pkg::OP_MINUS_ADDEND: begin
				accFirst = {32'h0000_0000, addendVal}; // RULE3
				subFirst = 1'b1;
			end
			wmd_pkg::OP_WIDE_DOUBLE_ACC: begin
				// high first, then low, both zero-extended
				accFirst = {32'h0000_0000, destHighVal}; // RULE12
				accSecond = {32'h0000_0000, destLowVal}; // RULE12
			end
			wmd_pkg::OP_WIDE_ACC: begin
				accFirst = {destHighVal, destLowVal}; // RULE14
			end
			default: begin
			end
		endcase
	end

	wmd_add_wide #(
		.W(64)
	) uAddFirst (
		.termA(product),
		.termB(accFirst),
		.reverseSub(subFirst),
		.sum(sumFirst)
	);

	wmd_add_wide #(
		.W(64)
	) uAddSecond (
		.termA(sumFirst),
		.termB(accSecond),
		.reverseSub(1'b0),
		.sum(sumFinal)
	);

	// ****************************************
	// operand checks
	// ****************************************
	function automatic logic isReserved(
		input logic [wmd_pkg::IDX_W-1:0] idx
	);
		isReserved = (idx == wmd_pkg::IDX_STACK_POINTER) ||
			(idx == wmd_pkg::IDX_PROGRAM_COUNTER);
	endfunction

	logic isWord;
	logic isWide;
	logic flagForm;
	logic [wmd_pkg::IDX_W-1:0] wordDest;
	logic badUse;

	always_comb begin
		isWord = (opSel == wmd_pkg::OP_PRODUCT_LOW) ||
			(opSel == wmd_pkg::OP_PLUS_ADDEND) ||
			(opSel == wmd_pkg::OP_MINUS_ADDEND);
		isWide = (opSel == wmd_pkg::OP_WIDE_PRODUCT) ||
			(opSel == wmd_pkg::OP_WIDE_DOUBLE_ACC) ||
			(opSel == wmd_pkg::OP_WIDE_ACC);
		flagForm = flagUpdate && (opSel == wmd_pkg::OP_PRODUCT_LOW); // RULE6
		wordDest = destNamed ? destIdx : firstIdx; // RULE5
		badUse = !(isWord || isWide);
		// misused operand registers are refused, not computed
		if (isReserved(firstIdx) || isReserved(secondIdx)) begin
			badUse = 1'b1; // RULE9
		end
		if (isWord && isReserved(wordDest)) begin
			badUse = 1'b1; // RULE9
		end
		if (((opSel == wmd_pkg::OP_PLUS_ADDEND) ||
			(opSel == wmd_pkg::OP_MINUS_ADDEND)) &&
			isReserved(addendIdx)) begin
			badUse = 1'b1; // RULE9
		end
		if (isWide && (isReserved(destHighIdx) ||
			isReserved(destLowIdx))) begin
			badUse = 1'b1; // RULE9
		end
		if (isWide && (destHighIdx == destLowIdx)) begin
			badUse = 1'b1; // RULE15
		end
		if (flagForm && ((wordDest > wmd_pkg::IDX_LOW_LIMIT) ||
			(firstIdx > wmd_pkg::IDX_LOW_LIMIT) ||
			(secondIdx > wmd_pkg::IDX_LOW_LIMIT) ||
			(wordDest != secondIdx) || condUsed)) begin
			badUse = 1'b1; // RULE8
		end
	end

	// ****************************************
	// write-back registers
	// ****************************************
	logic wrLowValid_d, wrLowValid_q;
	logic wrHighValid_d, wrHighValid_q;
	logic flagWrite_d, flagWrite_q;
	logic misuse_d, misuse_q;
	logic [wmd_pkg::IDX_W-1:0] wrLowIdx_d, wrLowIdx_q;
	logic [wmd_pkg::IDX_W-1:0] wrHighIdx_d, wrHighIdx_q;
	logic [31:0] wrLowData_d, wrLowData_q;
	logic [31:0] wrHighData_d, wrHighData_q;
	logic flagNeg_d, flagNeg_q;
	logic flagZero_d, flagZero_q;

	always_comb begin
		wrLowValid_d = 1'b0;
		wrHighValid_d = 1'b0;
		flagWrite_d = 1'b0;
		misuse_d = 1'b0;
		wrLowIdx_d = wrLowIdx_q;
		wrHighIdx_d = wrHighIdx_q;
		wrLowData_d = wrLowData_q;
		wrHighData_d = wrHighData_q;
		flagNeg_d = flagNeg_q;
		flagZero_d = flagZero_q;
		if (issueValid && badUse) begin
			misuse_d = 1'b1;
		end else if (issueValid && isWord) begin
			// low word is sign-independent, one multiplier serves both
			wrLowValid_d = 1'b1; // RULE4
			wrLowIdx_d = wordDest; // RULE5
			wrLowData_d = sumFinal[31:0]; // RULE1
			if (flagForm) begin
				// carry and overflow have no write path here
				flagWrite_d = 1'b1; // RULE7
				flagNeg_d = sumFinal[31]; // RULE7
				flagZero_d = (sumFinal[31:0] == 32'h0000_0000); // RULE7
			end
		end else if (issueValid && isWide) begin // RULE16
			wrLowValid_d = 1'b1; // RULE10
			wrHighValid_d = 1'b1;
			wrLowIdx_d = destLowIdx; // RULE11
			wrHighIdx_d = destHighIdx; // RULE11
			wrLowData_d = sumFinal[31:0]; // RULE13
			wrHighData_d = sumFinal[63:32]; // RULE13
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrLowValid_q <= 1'b0;
			wrHighValid_q <= 1'b0;
			flagWrite_q <= 1'b0;
			misuse_q <= 1'b0;
			wrLowIdx_q <= wmd_pkg::IDX_RESET;
			wrHighIdx_q <= wmd_pkg::IDX_RESET;
			wrLowData_q <= wmd_pkg::WORD_RESET;
			wrHighData_q <= wmd_pkg::WORD_RESET;
			flagNeg_q <= 1'b0;
			flagZero_q <= 1'b0;
		end else begin
			wrLowValid_q <= wrLowValid_d;
			wrHighValid_q <= wrHighValid_d;
			flagWrite_q <= flagWrite_d;
			misuse_q <= misuse_d;
			wrLowIdx_q <= wrLowIdx_d;
			wrHighIdx_q <= wrHighIdx_d;
			wrLowData_q <= wrLowData_d;
			wrHighData_q <= wrHighData_d;
			flagNeg_q <= flagNeg_d;
			flagZero_q <= flagZero_d;
		end
	end

	assign wrLowValid = wrLowValid_q;
	assign wrHighValid = wrHighValid_q;
	assign flagWrite = flagWrite_q;
	assign misuse = misuse_q;
	assign wrLowIdx = wrLowIdx_q;
	assign wrHighIdx = wrHighIdx_q;
	assign wrLowData = wrLowData_q;
	assign wrHighData = wrHighData_q;
	assign flagNeg = flagNeg_q;
	assign flagZero = flagZero_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cbMain @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic [63:0] refProd;
	logic [63:0] refSigned;
	always_comb begin
		refProd = {32'h0000_0000, firstVal} * {32'h0000_0000, secondVal};
		refSigned = 64'($signed(firstVal) * $signed(secondVal));
	end
	AST_PRODUCT_LOW: assert property ( // RULE1
		issueValid && opSel == wmd_pkg::OP_PRODUCT_LOW |=>
		misuse || (wrLowValid && !wrHighValid &&
		wrLowData == $past(refProd[31:0])))
		else $error("plain product low word wrong");
	AST_PLUS_ADDEND: assert property ( // RULE2
		issueValid && opSel == wmd_pkg::OP_PLUS_ADDEND |=>
		misuse || wrLowData == $past(refProd[31:0] + addendVal))
		else $error("product plus addend wrong");
	AST_MINUS_ADDEND: assert property ( // RULE3
		issueValid && opSel == wmd_pkg::OP_MINUS_ADDEND |=>
		misuse || wrLowData == $past(addendVal - refProd[31:0]))
		else $error("addend minus product wrong");
	AST_SIGN_FREE: assert property ( // RULE4
		issueValid && opSel == wmd_pkg::OP_PRODUCT_LOW |=>
		misuse || wrLowData == $past(refSigned[31:0]))
		else $error("word result depends on sign");
	AST_DEST_DEFAULT: assert property ( // RULE5
		issueValid && !destNamed &&
		opSel == wmd_pkg::OP_PLUS_ADDEND |=>
		misuse || wrLowIdx == $past(firstIdx))
		else $error("default destination not first operand");
	AST_FLAG_GATED: assert property ( // RULE6
		issueValid && !(flagUpdate &&
		opSel == wmd_pkg::OP_PRODUCT_LOW) |=> !flagWrite)
		else $error("flags written without update option");
	AST_FLAG_VALUES: assert property ( // RULE7
		flagWrite |-> wrLowValid && flagNeg == wrLowData[31] &&
		flagZero == (wrLowData == 32'h0000_0000))
		else $error("negative or zero flag wrong");
	AST_FLAG_REFUSE: assert property ( // RULE8
		issueValid && flagUpdate && condUsed &&
		opSel == wmd_pkg::OP_PRODUCT_LOW |=>
		misuse && !wrLowValid && !flagWrite)
		else $error("conditional flag product not refused");
	AST_RESERVED: assert property ( // RULE9
		issueValid && firstIdx == wmd_pkg::IDX_PROGRAM_COUNTER |=>
		misuse && !wrLowValid && !wrHighValid)
		else $error("reserved register not refused");
	AST_WIDE_PRODUCT: assert property ( // RULE11
		issueValid && opSel == wmd_pkg::OP_WIDE_PRODUCT |=>
		misuse || ({wrHighData, wrLowData} == $past(refProd) &&
		wrHighIdx == $past(destHighIdx) &&
		wrLowIdx == $past(destLowIdx)))
		else $error("wide product misplaced");
	AST_DOUBLE_ACC: assert property ( // RULE13
		issueValid && opSel == wmd_pkg::OP_WIDE_DOUBLE_ACC |=>
		misuse || {wrHighData, wrLowData} == $past(refProd +
		{32'h0000_0000, destHighVal} + {32'h0000_0000, destLowVal}))
		else $error("double accumulate wrong");
	AST_WIDE_ACC: assert property ( // RULE14
		issueValid && opSel == wmd_pkg::OP_WIDE_ACC |=>
		misuse || {wrHighData, wrLowData} ==
		$past(refProd + {destHighVal, destLowVal}))
		else $error("wide accumulate wrong");
	AST_SAME_DEST: assert property ( // RULE15
		issueValid && opSel >= wmd_pkg::OP_WIDE_PRODUCT &&
		opSel <= wmd_pkg::OP_WIDE_ACC && destHighIdx == destLowIdx |=>
		misuse && !wrLowValid && !wrHighValid)
		else $error("shared wide destination not refused");
	AST_WIDE_NOFLAG: assert property ( // RULE16
		issueValid && opSel >= wmd_pkg::OP_WIDE_PRODUCT &&
		opSel <= wmd_pkg::OP_WIDE_ACC |=> !flagWrite &&
		$stable(flagNeg) && $stable(flagZero))
		else $error("wide operation wrote flags");

	COV_FLAG_PRODUCT: cover property (
		issueValid && flagForm && !badUse ##1 flagWrite);
	COV_DOUBLE_ACC: cover property (
		issueValid && opSel == wmd_pkg::OP_WIDE_DOUBLE_ACC ##1
		wrHighValid);
	COV_MINUS: cover property (
		issueValid && opSel == wmd_pkg::OP_MINUS_ADDEND ##1 wrLowValid);
	COV_MISUSE: cover property (misuse);

endmodule // wmd_wide_multiply_datapath

`default_nettype wire

// ===== verification/wmd_regfile_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// issuer side register file
// ****************************************
module wmd_regfile_model (
	input wire logic clk,
	input wire logic ldEn,
	input wire logic [3:0] ldIdx,
	input wire logic [31:0] ldData,
	input wire logic wrLowValid,
	input wire logic [3:0] wrLowIdx,
	input wire logic [31:0] wrLowData,
	input wire logic wrHighValid,
	input wire logic [3:0] wrHighIdx,
	input wire logic [31:0] wrHighData,
	input wire logic [3:0] firstIdx,
	input wire logic [3:0] secondIdx,
	input wire logic [3:0] addendIdx,
	input wire logic [3:0] destHighIdx,
	input wire logic [3:0] destLowIdx,
	output logic [31:0] firstVal,
	output logic [31:0] secondVal,
	output logic [31:0] addendVal,
	output logic [31:0] destHighVal,
	output logic [31:0] destLowVal
);
	logic [31:0] regs [16];

	// bench loads win so a test can seed values over stale results
	always_ff @(posedge clk) begin
		if (wrLowValid) begin
			regs[wrLowIdx] <= wrLowData;
		end
		if (wrHighValid) begin
			regs[wrHighIdx] <= wrHighData;
		end
		if (ldEn) begin
			regs[ldIdx] <= ldData;
		end
	end

	assign firstVal = regs[firstIdx];
	assign secondVal = regs[secondIdx];
	assign addendVal = regs[addendIdx];
	assign destHighVal = regs[destHighIdx];
	assign destLowVal = regs[destLowIdx];
endmodule // wmd_regfile_model

`default_nettype wire

// ===== verification/wide_multiply_datapath_tb.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// multiply datapath bench
// ****************************************
module wide_multiply_datapath_tb;
	typedef struct packed {
		logic [2:0] op;
		logic fu;
		logic cd;
		logic [3:0] f;
		logic [3:0] dh;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] c;
		logic [31:0] h;
		logic [31:0] l;
		logic mis;
	} wmd_row_type;

	localparam int NROWS = 15;
	localparam logic [31:0] MX = 32'hffff_ffff;
	localparam wmd_row_type ROWS [NROWS] = '{
		'{3'h0, 1'b0, 1'b0, 4'h1, 4'h4, 32'h7, 32'h6, 32'h0, 32'h0, 32'h0, 1'b0},
		'{3'h0, 1'b1, 1'b0, 4'h1, 4'h4, 32'h0, 32'h9, 32'h0, 32'h0, 32'h0, 1'b0},
		'{3'h0, 1'b1, 1'b0, 4'h1, 4'h4, 32'hffff_fffd, 32'h5, 32'h0, 32'h0,
			32'h0, 1'b0},
		'{3'h1, 1'b0, 1'b0, 4'h1, 4'h4, MX, MX, 32'h5, 32'h0, 32'h0, 1'b0},
		'{3'h2, 1'b1, 1'b0, 4'h1, 4'h4, 32'h3, 32'h4, 32'h2, 32'h0, 32'h0, 1'b0},
		'{3'h3, 1'b1, 1'b0, 4'h1, 4'h4, MX, MX, 32'h0, 32'h0, 32'h0, 1'b0},
		'{3'h4, 1'b0, 1'b0, 4'h1, 4'h4, MX, MX, 32'h0, MX, MX, 1'b0},
		'{3'h5, 1'b0, 1'b0, 4'h1, 4'h4, MX, 32'h2, 32'h0, 32'h1, MX, 1'b0},
		'{3'h0, 1'b0, 1'b0, 4'hd, 4'h4, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 1'b1},
		'{3'h1, 1'b0, 1'b0, 4'hf, 4'h4, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 1'b1},
		'{3'h3, 1'b0, 1'b0, 4'h1, 4'h5, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 1'b1},
		'{3'h0, 1'b1, 1'b0, 4'h8, 4'h4, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 1'b1},
		'{3'h0, 1'b1, 1'b1, 4'h1, 4'h4, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 1'b1},
		'{3'h6, 1'b0, 1'b0, 4'h1, 4'h4, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 1'b1},
		'{3'h7, 1'b0, 1'b0, 4'h1, 4'h4, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 1'b1}
	};

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic issueValid = 1'b0;
	logic [2:0] opSel = 3'h0;
	logic flagUpdate = 1'b0;
	logic condUsed = 1'b0;
	logic destNamed = 1'b1;
	logic [3:0] destIdx = 4'h2;
	logic [3:0] firstIdx = 4'h1;
	logic [3:0] secondIdx = 4'h2;
	logic [3:0] addendIdx = 4'h3;
	logic [3:0] destHighIdx = 4'h4;
	logic [3:0] destLowIdx = 4'h5;
	logic ldEn = 1'b0;
	logic [3:0] ldIdx = 4'h0;
	logic [31:0] ldData = 32'h0000_0000;
	logic [31:0] firstVal, secondVal, addendVal, destHighVal, destLowVal;
	logic wrLowValid, wrHighValid, flagWrite, flagNeg, flagZero, misuse;
	logic [3:0] wrLowIdx, wrHighIdx;
	logic [31:0] wrLowData, wrHighData;
	int err_count = 0;
	int total_checks = 0;

	always #4 clk = ~clk;

	wmd_wide_multiply_datapath dut (.clk(clk), .rst_n(rst_n),
		.issueValid(issueValid), .opSel(opSel), .flagUpdate(flagUpdate),
		.condUsed(condUsed), .destNamed(destNamed), .destIdx(destIdx),
		.firstIdx(firstIdx), .secondIdx(secondIdx), .addendIdx(addendIdx),
		.destHighIdx(destHighIdx), .destLowIdx(destLowIdx),
		.firstVal(firstVal), .secondVal(secondVal), .addendVal(addendVal),
		.destHighVal(destHighVal), .destLowVal(destLowVal),
		.wrLowValid(wrLowValid), .wrLowIdx(wrLowIdx), .wrLowData(wrLowData),
		.wrHighValid(wrHighValid), .wrHighIdx(wrHighIdx),
		.wrHighData(wrHighData), .flagWrite(flagWrite), .flagNeg(flagNeg),
		.flagZero(flagZero), .misuse(misuse));

	wmd_regfile_model regfile (.clk(clk), .ldEn(ldEn), .ldIdx(ldIdx),
		.ldData(ldData), .wrLowValid(wrLowValid), .wrLowIdx(wrLowIdx),
		.wrLowData(wrLowData), .wrHighValid(wrHighValid),
		.wrHighIdx(wrHighIdx), .wrHighData(wrHighData), .firstIdx(firstIdx),
		.secondIdx(secondIdx), .addendIdx(addendIdx),
		.destHighIdx(destHighIdx), .destLowIdx(destLowIdx),
		.firstVal(firstVal), .secondVal(secondVal), .addendVal(addendVal),
		.destHighVal(destHighVal), .destLowVal(destLowVal));

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] expv);
		total_checks++;
		if (seen !== expv) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic load(input logic [3:0] idx, input logic [31:0] data);
		ldEn = 1'b1;
		ldIdx = idx;
		ldData = data;
		@(negedge clk);
		// caller drops the enable after its last load, never mid-burst
	endtask

	// expected results straight from the operand values
	function automatic logic [63:0] expect_of(input wmd_row_type r);
		logic [63:0] p;
		p = {32'h0000_0000, r.a} * {32'h0000_0000, r.b};
		case (r.op)
			3'h1: expect_of = p + {32'h0000_0000, r.c};
			3'h2: expect_of = {32'h0000_0000, r.c} - p;
			3'h4: expect_of = p + {32'h0000_0000, r.h} + {32'h0000_0000, r.l};
			3'h5: expect_of = p + {r.h, r.l};
			default: expect_of = p;
		endcase
	endfunction

	initial begin
		#100000;
		err_count++;
		complete_run();
	end

	initial begin
		wmd_row_type r;
		logic [63:0] e;
		logic wide;
		logic fw;
		repeat (16) @(negedge clk);
		check({wrLowValid, wrHighValid, flagWrite, misuse}, 64'h0);
		rst_n = 1'b1;
		@(negedge clk);
		for (int i = 0; i < NROWS; i++) begin
			r = ROWS[i];
			// issuer keeps indices legal except in refusal rows
			load(r.f, r.a);
			load(4'h2, r.b);
			load(4'h3, r.c);
			load(r.dh, r.h);
			load(4'h5, r.l);
			ldEn = 1'b0;
			e = expect_of(r);
			wide = (r.op >= 3'h3) && (r.op <= 3'h5) && !r.mis;
			fw = (r.op == 3'h0) && r.fu && !r.mis;
			opSel = r.op;
			flagUpdate = r.fu;
			condUsed = r.cd;
			firstIdx = r.f;
			destHighIdx = r.dh;
			issueValid = 1'b1;
			@(negedge clk);
			issueValid = 1'b0;
			check(misuse, r.mis);
			check(wrLowValid, !r.mis);
			check(wrHighValid, wide);
			check(flagWrite, fw);
			if (!r.mis) begin
				check(wrLowData, e[31:0]);
				check(wrLowIdx, wide ? 4'h5 : 4'h2);
			end
			if (wide) begin
				check(wrHighData, e[63:32]);
				check(wrHighIdx, r.dh);
			end
			if (fw) begin
				check({flagNeg, flagZero}, {e[31], e[31:0] == 0});
			end
		end
		// no destination named: first operand register takes the result
		load(4'h1, 32'h3);
		load(4'h2, 32'h4);
		load(4'h3, 32'ha);
		ldEn = 1'b0;
		firstIdx = 4'h1;
		destNamed = 1'b0;
		opSel = 3'h0;
		flagUpdate = 1'b0;
		condUsed = 1'b0;
		issueValid = 1'b1;
		@(negedge clk);
		// back to back: second request sees values before the first write
		opSel = 3'h1;
		check(wrLowIdx, 4'h1);
		check(wrLowData, 32'hc);
		@(negedge clk);
		destNamed = 1'b1;
		check(wrLowData, 32'h16);
		check(wrLowIdx, 4'h1);
		// request held into a mid-run reset is dropped
		rst_n = 1'b0;
		opSel = 3'h3;
		@(negedge clk);
		issueValid = 1'b0;
		check({wrLowValid, wrHighValid, flagWrite, misuse, wrLowData}, 64'h0);
		rst_n = 1'b1;
		@(negedge clk);
		check({wrLowValid, wrHighValid, flagWrite, misuse, wrLowData}, 64'h0);
		complete_run();
	end
endmodule // wide_multiply_datapath_tb

`default_nettype wire
